// ==== mmu_pkg.sv ====
package mmu_pkg;

  // ----------------------------------------------------------------
  // register map, byte offsets on the bus (index = offset / 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONFIG = 8'h00; // core_config_reg
  localparam logic [7:0] OFF_ROOT = 8'h04; // page_table_root_reg
  localparam logic [7:0] OFF_DOMAIN = 8'h08; // domain rights
  localparam logic [7:0] OFF_FLUSH = 8'h0c; // translation_flush_reg
  localparam logic [7:0] OFF_FLUSH_ENTRY = 8'h10; // single data entry invalidate
  localparam logic [7:0] OFF_FAULT_STATUS = 8'h14;
  localparam logic [7:0] OFF_FAULT_ADDR = 8'h18;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_XLAT = 0;
  localparam int CFG_DCACHE = 2;
  localparam int CFG_WBUF = 3;
  localparam int CFG_ICACHE = 12;
  localparam int FL_DATA_ALL = 0;
  localparam int FL_INSTR_ALL = 1;
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_ROOT = 32'h0000_0000;
  localparam logic [31:0] RST_DOMAIN = 32'h0000_0000;

  // ----------------------------------------------------------------
  // codes and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CP_NUM_SYS = 4'hf; // the only coprocessor served
  localparam logic [1:0] ACC_HALF = 2'h1;
  localparam logic [1:0] ACC_WORD = 2'h2;
  localparam logic [1:0] L1_COARSE = 2'h1;
  localparam logic [1:0] L1_SECTION = 2'h2;
  localparam logic [1:0] L2_LARGE = 2'h1;
  localparam logic [1:0] L2_SMALL = 2'h2;
  localparam logic [1:0] DOM_CLIENT = 2'h1;
  localparam logic [1:0] DOM_MANAGER = 2'h3;
  localparam logic [1:0] AP_PRIV_ONLY = 2'h1;
  localparam logic [1:0] AP_USER_RO = 2'h2;
  localparam logic [1:0] AP_FULL = 2'h3;
  localparam logic [3:0] FS_NONE = 4'h0;
  localparam logic [3:0] FS_ALIGN = 4'h1;
  localparam logic [3:0] FS_TRANS = 4'h5;
  localparam logic [3:0] FS_EXT = 4'h8;
  localparam logic [3:0] FS_DOMAIN = 4'h9;
  localparam logic [3:0] FS_PERM = 4'hd;
  localparam logic [3:0] RESERVED_NIBBLE = 4'hf; // top 256 MB is reserved space
  localparam logic [1:0] FLAT_FETCHES = 2'h3;
  localparam int TLB_ENTRIES = 32;
  localparam int TLB_IDX_W = 5;

  typedef enum logic [1:0] {MAP_SECTION = 2'h0, MAP_LARGE = 2'h1, MAP_SMALL = 2'h2} map_size_t;

  typedef struct packed {
    logic valid;
    map_size_t size;
    logic [19:0] vtag; // va[31:12]
    logic [19:0] ptag; // pa[31:12]
    logic [1:0] ap;
    logic [3:0] dom;
  } tlb_entry_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_LOOK = 3'h1, ST_WALK1 = 3'h3, ST_WALK2 = 3'h2, ST_DONE = 3'h6
  } xl_state_t;

endpackage

// ==== mmu_translation_control.sv ====
// Operation
// - only coprocessor 15 is served; any other number answers undefined instruction
// - register access only from privileged mode (the AHB-Lite port has no mode check); unknown register numbers read zero
// - two 32-entry fully associative buffers, one instruction, one data
// - an entry maps a section, large page or small page with permissions
// - miss starts a table walk; buffer loaded only for valid mappings
// - victim chosen round-robin
// - invalid descriptor aborts and is never written into the buffer
// - data buffer: invalidate all and single entry; instruction buffer: all only
// - misaligned word or halfword access raises alignment fault
// - access to an invalid mapping raises translation fault
// - mode, domain or protection bits disallowing access raise domain/permission fault
// - any data-side fault or reserved-space access raises data abort
// - abort on any word of a line fill purges the partial line
// - abort before requested word returned aborts the load
// - abort after requested word returned cancels fill, load completes, no exception
// - instruction cache enable is independent of translation enable
// - three fetches after a translation switch keep old addressing
// - toggling translation leaves buffer contents unchanged
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// translation buffer
// ----------------------------------------------------------------
module tlb_array
  import mmu_pkg::*;
#(
  parameter int ENTRIES = TLB_ENTRIES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [31:0] look_va,
  output logic hit,
  output tlb_entry_t hit_entry,
  input wire logic fill,
  input wire tlb_entry_t fill_entry,
  input wire logic inv_all,
  input wire logic inv_one,
  input wire logic [31:0] inv_va
);

  tlb_entry_t entry [ENTRIES];
  logic [TLB_IDX_W-1:0] victim;
  logic [ENTRIES-1:0] match;
  logic [ENTRIES-1:0] inv_match;

  // tag compare width follows the mapping size
  function automatic logic tag_eq(input tlb_entry_t e, input logic [31:0] va);
    logic eq;
    eq = 1'b0;
    unique case (e.size)
      MAP_SECTION: eq = (e.vtag[19:8] == va[31:20]);
      MAP_LARGE: eq = (e.vtag[19:4] == va[31:16]);
      default: eq = (e.vtag == va[31:12]);
    endcase
    return e.valid && eq;
  endfunction

  // every entry is compared at once, fully associative
  for (genvar i = 0; i < ENTRIES; i++) begin : g_cmp
    assign match[i] = tag_eq(entry[i], look_va);
    assign inv_match[i] = tag_eq(entry[i], inv_va);
  end

  assign hit = |match;

  // entries never overlap after a flush, so an or-reduction selects the hit
  always_comb begin
    hit_entry = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (match[i]) begin
        hit_entry = hit_entry | entry[i];
      end
    end
  end

  // fill at the round-robin victim; invalidates clear valid only
  always_ff @(posedge mclk) begin
    if (rst) begin
      victim <= '0;
      for (int i = 0; i < ENTRIES; i++) begin
        entry[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (inv_all || (inv_one && inv_match[i])) begin
          entry[i].valid <= 1'b0;
        end
      end
      if (fill) begin
        entry[victim] <= fill_entry;
        victim <= victim + 1'b1;
      end
    end
  end

endmodule

// ----------------------------------------------------------------
// translation control top
// ----------------------------------------------------------------
module mmu_translation_control
  import mmu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cp_req,
  input wire logic [3:0] cp_num,
  input wire logic [3:0] cp_reg,
  input wire logic cp_write,
  input wire logic cp_priv,
  input wire logic [31:0] cp_wdata,
  output logic cp_done,
  output logic cp_undef,
  output logic [31:0] cp_rdata,
  input wire logic if_req,
  input wire logic [31:0] if_vaddr,
  input wire logic if_priv,
  output logic if_ack,
  output logic if_abort,
  output logic [31:0] if_paddr,
  input wire logic d_req,
  input wire logic [31:0] d_vaddr,
  input wire logic [1:0] d_size,
  input wire logic d_write,
  input wire logic d_priv,
  output logic d_ack,
  output logic d_abort,
  output logic [31:0] d_paddr,
  output logic walk_req,
  output logic [31:0] walk_addr,
  input wire logic walk_ack,
  input wire logic walk_err,
  input wire logic [31:0] walk_rdata,
  input wire logic fill_active,
  input wire logic fill_word_done,
  input wire logic fill_bus_err,
  output logic line_purge,
  output logic load_abort,
  output logic fill_cancel,
  output logic xlat_en,
  output logic dcache_en,
  output logic wbuf_en,
  output logic icache_en
);

  logic [31:0] cfg;
  logic [31:0] root;
  logic [31:0] domain;
  logic [31:0] fault_status;
  logic [31:0] fault_addr;
  logic ap_wr;
  logic [5:0] ap_idx;
  xl_state_t state;
  logic cur_data;
  logic cur_write;
  logic cur_priv;
  logic [1:0] cur_size;
  logic [31:0] cur_va;
  logic [3:0] walk_dom;
  logic eff_xlat;
  logic [1:0] flat_cnt;
  logic crit_seen;

  // ----------------------------------------------------------------
  // register access: bus data phase and coprocessor port
  // ----------------------------------------------------------------
  function automatic logic [31:0] reg_read(input logic [5:0] idx, input logic [31:0] c, input logic [31:0] r,
                                           input logic [31:0] d, input logic [31:0] fs, input logic [31:0] fa);
    logic [31:0] v;
    v = 32'h0000_0000; // unimplemented numbers read zero
    if (idx == OFF_CONFIG[7:2]) v = c;
    if (idx == OFF_ROOT[7:2]) v = r;
    if (idx == OFF_DOMAIN[7:2]) v = d;
    if (idx == OFF_FAULT_STATUS[7:2]) v = fs;
    if (idx == OFF_FAULT_ADDR[7:2]) v = fa;
    return v;
  endfunction

  wire ahb_take = hsel && htrans[1] && hready;
  wire ahb_on_map = (haddr[31:8] == 24'h00_0000);
  // a bus write holds the write port; the coprocessor request simply waits a cycle
  wire cp_take = cp_req && !cp_done && !ap_wr;
  wire cp_legal = (cp_num == CP_NUM_SYS) && cp_priv;
  wire cp_wr = cp_take && cp_legal && cp_write;
  wire wr_en = ap_wr || cp_wr;
  wire [5:0] wr_idx = ap_wr ? ap_idx : {2'b00, cp_reg};
  wire [31:0] wr_data = ap_wr ? hwdata : cp_wdata;
  wire wr_cfg = wr_en && (wr_idx == OFF_CONFIG[7:2]);
  wire wr_flush = wr_en && (wr_idx == OFF_FLUSH[7:2]);
  wire inv_d_all = wr_flush && wr_data[FL_DATA_ALL];
  wire inv_i_all = wr_flush && wr_data[FL_INSTR_ALL];
  wire inv_d_one = wr_en && (wr_idx == OFF_FLUSH_ENTRY[7:2]);
  wire xlat_toggle = wr_cfg && (wr_data[CFG_XLAT] != cfg[CFG_XLAT]);

  // zero-wait slave: read data is fetched at the address phase edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      ap_wr <= 1'b0;
      ap_idx <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_wr <= ahb_take && hwrite && ahb_on_map;
      ap_idx <= haddr[7:2];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ahb_take && !hwrite) begin
        hrdata <= ahb_on_map ? reg_read(haddr[7:2], cfg, root, domain, fault_status, fault_addr) : 32'h0000_0000;
      end
    end
  end

  // coprocessor answer one cycle after it is taken
  always_ff @(posedge mclk) begin
    if (rst) begin
      cp_done <= 1'b0;
      cp_undef <= 1'b0;
      cp_rdata <= '0;
    end else begin
      cp_done <= cp_take;
      cp_undef <= cp_take && !cp_legal;
      if (cp_take && cp_legal && !cp_write) begin
        cp_rdata <= reg_read({2'b00, cp_reg}, cfg, root, domain, fault_status, fault_addr);
      end
    end
  end

  // configuration registers; a translation switch never touches the buffers
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg <= RST_CONFIG;
      root <= RST_ROOT;
      domain <= RST_DOMAIN;
    end else if (wr_en) begin
      if (wr_cfg) cfg <= wr_data;
      if (wr_idx == OFF_ROOT[7:2]) root <= wr_data;
      if (wr_idx == OFF_DOMAIN[7:2]) domain <= wr_data;
    end
  end

  // enables come straight from the register; no interlock between them
  assign xlat_en = cfg[CFG_XLAT];
  assign dcache_en = cfg[CFG_DCACHE];
  assign wbuf_en = cfg[CFG_WBUF];
  assign icache_en = cfg[CFG_ICACHE];

  // ----------------------------------------------------------------
  // lookup and checks
  // ----------------------------------------------------------------
  logic i_hit;
  logic d_hit;
  tlb_entry_t i_entry;
  tlb_entry_t d_entry;
  tlb_entry_t new_entry;
  logic i_fill;
  logic d_fill;

  tlb_array #(.ENTRIES(TLB_ENTRIES)) u_itlb (
    .mclk(mclk), .rst(rst), .look_va(cur_va), .hit(i_hit), .hit_entry(i_entry),
    .fill(i_fill), .fill_entry(new_entry), .inv_all(inv_i_all), .inv_one(1'b0), .inv_va(32'h0000_0000)
  );

  tlb_array #(.ENTRIES(TLB_ENTRIES)) u_dtlb (
    .mclk(mclk), .rst(rst), .look_va(cur_va), .hit(d_hit), .hit_entry(d_entry),
    .fill(d_fill), .fill_entry(new_entry), .inv_all(inv_d_all), .inv_one(inv_d_one), .inv_va(wr_data)
  );

  wire look_hit = cur_data ? d_hit : i_hit;
  wire tlb_entry_t look_entry = cur_data ? d_entry : i_entry;
  // instruction side sees the delayed setting, data side the register itself
  wire xlat_on = cur_data ? cfg[CFG_XLAT] : eff_xlat;
  wire misaligned = cur_data && (((cur_size == ACC_WORD) && (cur_va[1:0] != 2'b00)) ||
                                 ((cur_size == ACC_HALF) && cur_va[0]));
  wire [1:0] dom_bits = domain[{look_entry.dom, 1'b0} +: 2];
  wire dom_pass = (dom_bits == DOM_CLIENT) || (dom_bits == DOM_MANAGER);
  wire ap_pass = (dom_bits == DOM_MANAGER) || (look_entry.ap == AP_FULL) ||
                 ((look_entry.ap == AP_USER_RO) && (cur_priv || !cur_write)) ||
                 ((look_entry.ap == AP_PRIV_ONLY) && cur_priv);
  wire [31:0] hit_paddr = (look_entry.size == MAP_SECTION) ? {look_entry.ptag[19:8], cur_va[19:0]} :
                          (look_entry.size == MAP_LARGE) ? {look_entry.ptag[19:4], cur_va[15:0]} :
                          {look_entry.ptag, cur_va[11:0]};
  wire [31:0] out_paddr = xlat_on ? hit_paddr : cur_va;
  wire reserved = cur_data && (out_paddr[31:28] == RESERVED_NIBBLE);

  // fault priority: alignment, domain, permission, reserved space
  wire [3:0] look_fault = misaligned ? FS_ALIGN :
                          (xlat_on && !dom_pass) ? FS_DOMAIN :
                          (xlat_on && !ap_pass) ? FS_PERM :
                          reserved ? FS_EXT : FS_NONE;

  // ----------------------------------------------------------------
  // table walk decode
  // ----------------------------------------------------------------
  wire [1:0] desc_type = walk_rdata[1:0];
  wire walk_ok = (state == ST_WALK1 || state == ST_WALK2) && walk_ack && !walk_err;
  wire l1_section = walk_ok && (state == ST_WALK1) && (desc_type == L1_SECTION);
  wire l1_coarse = walk_ok && (state == ST_WALK1) && (desc_type == L1_COARSE);
  wire l2_page = walk_ok && (state == ST_WALK2) && ((desc_type == L2_LARGE) || (desc_type == L2_SMALL));
  wire walk_fill = l1_section || l2_page;
  wire walk_bad = (state == ST_WALK1 || state == ST_WALK2) && walk_ack && !walk_fill && !l1_coarse;

  // entry built from the descriptor; only stored when the mapping is valid
  always_comb begin
    new_entry = '0;
    new_entry.valid = 1'b1;
    new_entry.vtag = cur_va[31:12];
    new_entry.ptag = walk_rdata[31:12];
    if (state == ST_WALK1) begin
      new_entry.size = MAP_SECTION;
      new_entry.ap = walk_rdata[11:10];
      new_entry.dom = walk_rdata[8:5];
    end else begin
      new_entry.size = (desc_type == L2_LARGE) ? MAP_LARGE : MAP_SMALL;
      new_entry.ap = walk_rdata[5:4];
      new_entry.dom = walk_dom;
    end
  end

  assign i_fill = walk_fill && !cur_data;
  assign d_fill = walk_fill && cur_data;

  // ----------------------------------------------------------------
  // request sequencer
  // ----------------------------------------------------------------
  wire look_done = (state == ST_LOOK) && (misaligned || !xlat_on || look_hit);
  wire fin = look_done || walk_bad;
  wire [3:0] fin_code = walk_bad ? FS_TRANS : look_fault;
  wire fin_fault = fin && (fin_code != FS_NONE);

  // one request at a time; data side wins over fetch
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
      cur_data <= 1'b0;
      cur_write <= 1'b0;
      cur_priv <= 1'b0;
      cur_size <= '0;
      cur_va <= '0;
      walk_dom <= '0;
      walk_req <= 1'b0;
      walk_addr <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (d_req || if_req) begin
            cur_data <= d_req;
            cur_va <= d_req ? d_vaddr : if_vaddr;
            cur_write <= d_req && d_write;
            cur_size <= d_req ? d_size : ACC_WORD;
            cur_priv <= d_req ? d_priv : if_priv;
            state <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          if (fin) begin
            state <= ST_DONE;
          end else begin
            walk_req <= 1'b1;
            walk_addr <= {root[31:14], cur_va[31:20], 2'b00};
            state <= ST_WALK1;
          end
        end
        ST_WALK1: begin
          if (walk_ack) begin
            walk_req <= l1_coarse;
            walk_addr <= {walk_rdata[31:10], cur_va[19:12], 2'b00};
            walk_dom <= walk_rdata[8:5];
            state <= l1_coarse ? ST_WALK2 : (walk_fill ? ST_LOOK : ST_DONE);
          end
        end
        ST_WALK2: begin
          if (walk_ack) begin
            walk_req <= 1'b0;
            state <= walk_fill ? ST_LOOK : ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE; // lets the requester drop its request
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // answers to the pipeline, one-cycle pulses
  always_ff @(posedge mclk) begin
    if (rst) begin
      if_ack <= 1'b0;
      if_abort <= 1'b0;
      if_paddr <= '0;
      d_ack <= 1'b0;
      d_abort <= 1'b0;
      d_paddr <= '0;
    end else begin
      if_ack <= fin && !cur_data;
      if_abort <= fin_fault && !cur_data;
      d_ack <= fin && cur_data;
      d_abort <= fin_fault && cur_data;
      if (fin && !cur_data) if_paddr <= out_paddr;
      if (fin && cur_data) d_paddr <= out_paddr;
    end
  end

  // data faults record cause, domain and address
  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_status <= '0;
      fault_addr <= '0;
    end else if (fin_fault && cur_data) begin
      fault_status <= {24'h00_0000, (walk_bad ? walk_dom : look_entry.dom), fin_code};
      fault_addr <= cur_va;
    end
  end

  // old addressing holds for the next three completed fetches after a switch
  always_ff @(posedge mclk) begin
    if (rst) begin
      flat_cnt <= '0;
      eff_xlat <= 1'b0;
    end else begin
      if (xlat_toggle) begin
        flat_cnt <= FLAT_FETCHES;
      end else if ((flat_cnt != 2'h0) && if_ack) begin
        flat_cnt <= flat_cnt - 2'h1;
      end
      if (flat_cnt == 2'h0 && !xlat_toggle) begin
        eff_xlat <= cfg[CFG_XLAT];
      end
    end
  end

  // ----------------------------------------------------------------
  // aborted line fill
  // ----------------------------------------------------------------
  wire fill_abort = fill_active && fill_bus_err;

  // an error in the same cycle as the requested word counts as before it
  always_ff @(posedge mclk) begin
    if (rst) begin
      crit_seen <= 1'b0;
      line_purge <= 1'b0;
      load_abort <= 1'b0;
      fill_cancel <= 1'b0;
    end else begin
      crit_seen <= fill_active && (crit_seen || fill_word_done);
      line_purge <= fill_abort;
      load_abort <= fill_abort && !crit_seen;
      fill_cancel <= fill_abort && crit_seen;
    end
  end

endmodule

`default_nettype wire

// ==== xlat_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------
// port checker
// ------
module xlat_ctrl_monitor
  import mmu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cp_req,
  input wire logic [3:0] cp_num,
  input wire logic cp_priv,
  input wire logic cp_done,
  input wire logic cp_undef,
  input wire logic [31:0] d_vaddr,
  input wire logic [1:0] d_size,
  input wire logic d_ack,
  input wire logic d_abort,
  input wire logic walk_req,
  input wire logic walk_ack,
  input wire logic fill_active,
  input wire logic fill_word_done,
  input wire logic fill_bus_err,
  input wire logic line_purge,
  input wire logic load_abort,
  input wire logic fill_cancel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire odd = (d_size == ACC_WORD && d_vaddr[1:0] != 2'h0) || (d_size == ACC_HALF && d_vaddr[0]);
  // fill error, and fill error once the wanted word is back
  sequence err_s;
    fill_active && fill_bus_err;
  endsequence
  sequence late_s;
    fill_word_done ##1 (err_s and !fill_word_done);
  endsequence
  a_undef_num: assert property (cp_done && cp_num != CP_NUM_SYS |-> cp_undef) else $error("cp number");
  a_undef_user: assert property (cp_done && !cp_priv |-> cp_undef) else $error("user mode");
  a_cp_answer: assert property ($rose(cp_req) |-> ##[1:4] cp_done) else $error("cp late");
  a_align_abort: assert property (d_ack && odd |-> d_abort) else $error("align");
  a_walk_hold: assert property (walk_req && !walk_ack |=> walk_req) else $error("walk drop");
  a_purge_err: assert property (err_s |=> line_purge) else $error("purge");
  a_early_abort: assert property (err_s ##0 !$past(fill_word_done) |=> load_abort && !fill_cancel)
    else $error("early");
  a_late_cancel: assert property (late_s |=> fill_cancel && !load_abort) else $error("late");
endmodule
`default_nettype wire

// ==== page_table_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------
// table memory behind the walker
// ------
module page_table_model
  import mmu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] lat,
  input wire logic walk_req,
  input wire logic [31:0] walk_addr,
  output logic walk_ack,
  output logic walk_err,
  output logic [31:0] walk_rdata,
  output logic [31:0] n_walk
);
  logic [3:0] cnt;
  wire [11:0] idx = walk_addr[13:2];
  // sections only; slot 5 gives a bus error, unlisted slots are invalid
  function automatic logic [31:0] desc(input logic [11:0] i);
    case (i)
      12'h001: desc = {12'h101, 8'h00, AP_FULL, 5'h00, 3'h0, L1_SECTION};
      12'h004: desc = {12'h104, 8'h00, AP_PRIV_ONLY, 5'h00, 3'h0, L1_SECTION};
      12'h006: desc = {12'hf06, 8'h00, AP_FULL, 5'h00, 3'h0, L1_SECTION};
      default: desc = 32'h0000_0000;
    endcase
  endfunction
  // data is inverted each cycle outside an answer, so a stale word never stays steady
  always @(posedge mclk) begin
    if (rst) begin
      walk_ack <= 1'b0;
      walk_err <= 1'b0;
      walk_rdata <= 32'h0;
      cnt <= 4'h0;
      n_walk <= 32'h0;
    end else if (walk_req && !walk_ack && cnt >= lat) begin
      walk_ack <= 1'b1;
      walk_err <= idx == 12'h005;
      walk_rdata <= desc(idx);
      cnt <= 4'h0;
      n_walk <= n_walk + 32'h1;
    end else begin
      walk_ack <= 1'b0;
      walk_err <= 1'b0;
      walk_rdata <= ~walk_rdata;
      cnt <= walk_req ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ==== test_mmu_translation_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_mmu_translation_control
  import mmu_pkg::*;
;
  logic mclk, rst, hsel, hwrite, cp_req, cp_write, cp_priv, if_req, if_priv, d_req, d_write, d_priv, rd_ph;
  logic fill_active, fill_word_done, fill_bus_err, hreadyout, hresp, cp_done, cp_undef, if_ack, if_abort;
  logic d_ack, d_abort, walk_req, walk_ack, walk_err, line_purge, load_abort, fill_cancel;
  logic xlat_en, dcache_en, wbuf_en, icache_en;
  logic [1:0] htrans, d_size;
  logic [2:0] hsize;
  logic [3:0] cp_num, cp_reg, lat;
  logic [31:0] haddr, hwdata, hrdata, cp_wdata, cp_rdata, if_vaddr, if_paddr, d_vaddr, d_paddr;
  logic [31:0] walk_addr, walk_rdata, n_walk, seed;
  logic [65:0] q_ack[$];
  logic [31:0] q_rd[$];
  logic [31:0] va[6] = '{32'h0020_0000, 32'h0050_0000, 32'h0040_0000, 32'h0060_0000, 32'h0010_0002, 32'h0010_0001};
  logic [3:0] fs[6] = '{FS_TRANS, FS_TRANS, FS_PERM, FS_EXT, FS_ALIGN, FS_ALIGN};
  logic [15:0] cv[6] = '{16'h1000, 16'h100d, 16'h1005, 16'h1001, 16'h0001, 16'h0000};
  int err_total, n_compared;
  // the one slave's ready is the bus ready; every other pin shares its name
  mmu_translation_control i_dut (.hready(hreadyout), .*);
  page_table_model i_mem (.*);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [32:0] got, input logic [65:0] e);
    n_compared++;
    if ((got & e[65:33]) !== (e[32:0] & e[65:33])) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e[32:0]);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // results are matched against the oldest note as they appear
  always @(posedge mclk) begin
    if (cp_done || d_ack || if_ack) chk(cp_done ? {cp_undef, cp_rdata} : d_ack ? {d_abort, d_paddr}
      : {if_abort, if_paddr}, q_ack.pop_front());
    if (line_purge) chk({31'h0, load_abort, fill_cancel}, q_ack.pop_front());
    if (rd_ph) chk({1'b0, hrdata}, {33'h0ffffffff, 1'b0, q_rd.pop_front()});
  end
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    if (!w) q_rd.push_back(d);
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    rd_ph <= 1'b0;
  endtask
  // kind 0 data, 1 fetch, 2 coprocessor; m asks for the data word to be compared
  task automatic req(input int k, input logic [31:0] a, input logic m, input logic ab, input logic [31:0] e);
    q_ack.push_back({1'b1, {32{m}}, ab, e});
    d_req <= k == 0;
    if_req <= k == 1;
    cp_req <= k == 2;
    {d_vaddr, if_vaddr, cp_wdata} <= {a, a, a};
    @(posedge mclk);
    while (!(d_ack || if_ack || cp_done)) @(posedge mclk);
    {d_req, if_req, cp_req} <= 3'h0;
    @(posedge mclk);
  endtask
  task automatic walks(input int n);
    chk({1'b0, n_walk}, {1'b1, 32'hffffffff, 1'b0, 32'(n)});
  endtask
  initial begin
    {hsel, hwrite, cp_req, cp_write, if_req, d_req, d_write, fill_active, fill_word_done, fill_bus_err} = '0;
    {htrans, haddr, hwdata, cp_num, cp_reg, cp_wdata, if_vaddr, d_vaddr, d_size, lat, rd_ph} = '0;
    {cp_priv, if_priv, d_priv, hsel, rst} = '1;
    hsize = 3'h2;
    seed = 32'hd505;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    ahb(0, 32'(OFF_CONFIG), RST_CONFIG);
    ahb(1, 32'(OFF_DOMAIN), {30'h0, DOM_CLIENT});
    ahb(0, 32'h0000_0100, 32'h0);
    $display("test 1 done");
    cp_reg <= 4'(OFF_DOMAIN >> 2);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      cp_num <= (i == 4) ? CP_NUM_SYS : seed[3:0] ^ {3'h0, seed[3:0] == CP_NUM_SYS};
      cp_priv <= i != 4;
      req(2, 32'h0, 0, 1, 32'h0);
    end
    cp_priv <= 1'b1;
    req(2, 32'h0, 1, 0, {30'h0, DOM_CLIENT});
    {cp_reg, cp_write} <= 5'h01;
    req(2, 32'h1, 0, 0, 32'h0);
    $display("test 2 done");
    for (int i = 0; i < 4; i++) req(1, 32'h0010_0040, 1, 0, i < 3 ? 32'h0010_0040 : 32'h1010_0040);
    d_size <= ACC_WORD;
    seed = xs(seed);
    for (int i = 0; i < 2; i++) req(0, {12'h001, seed[19:2], 2'h0}, 1, 0, {12'h101, seed[19:2], 2'h0});
    walks(2);
    $display("test 3 done");
    lat <= 4'h3;
    for (int i = 0; i < 6; i++) begin
      d_size <= i == 5 ? ACC_HALF : ACC_WORD;
      d_priv <= i != 2;
      req(0, va[i], 0, 1, 32'h0);
      ahb(0, 32'(OFF_FAULT_STATUS), {28'h0, fs[i]});
    end
    walks(6);
    {d_priv, d_size} <= {1'b1, ACC_WORD};
    req(0, va[0], 0, 1, 32'h0);
    walks(7);
    $display("test 4 done");
    ahb(1, 32'(OFF_FLUSH), 32'h3);
    req(0, 32'h0010_0000, 1, 0, 32'h1010_0000);
    req(1, 32'h0010_0000, 1, 0, 32'h1010_0000);
    ahb(1, 32'(OFF_FLUSH_ENTRY), 32'h0010_0000);
    req(0, 32'h0010_0000, 1, 0, 32'h1010_0000);
    walks(10);
    ahb(1, 32'(OFF_CONFIG), 32'h0);
    ahb(1, 32'(OFF_CONFIG), 32'h1);
    req(0, 32'h0010_0000, 1, 0, 32'h1010_0000);
    walks(10);
    $display("test 5 done");
    // legal combinations only, switched off in the prescribed order
    for (int i = 0; i < 6; i++) begin
      ahb(1, 32'(OFF_CONFIG), {16'h0, cv[i]});
      @(posedge mclk);
      chk({29'h0, xlat_en, dcache_en, wbuf_en, icache_en}, {33'hf, 29'h0, cv[i][CFG_XLAT], cv[i][CFG_DCACHE],
        cv[i][CFG_WBUF], cv[i][CFG_ICACHE]});
    end
    $display("test 6 done");
    for (int i = 0; i < 2; i++) begin
      q_ack.push_back({33'h3, 31'h0, i == 0, i == 1});
      fill_active <= 1'b1;
      fill_word_done <= i == 1;
      @(posedge mclk);
      fill_word_done <= 1'b0;
      fill_bus_err <= 1'b1;
      @(posedge mclk);
      {fill_bus_err, fill_active} <= 2'h0;
      repeat (3) @(posedge mclk);
    end
    $display("test 7 done");
    summarize();
  end
  // cut a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    summarize();
  end
endmodule
bind mmu_translation_control xlat_ctrl_monitor i_chk (.*);
`default_nettype wire
